// >>> common/cpe_pkg.sv
// Shared constants and carrier types for the current and power calculation engine
package cpe_pkg;

    // Register indices
    localparam logic [7:0] IDX_OPERATING_SETUP = 8'h00;
    localparam logic [7:0] IDX_SHUNT_DROP      = 8'h01;
    localparam logic [7:0] IDX_RAIL_VOLTAGE    = 8'h02;
    localparam logic [7:0] IDX_POWER           = 8'h03;
    localparam logic [7:0] IDX_CURRENT         = 8'h04;
    localparam logic [7:0] IDX_SCALING_WORD    = 8'h05;

    // Reset values
    localparam logic [15:0] SETUP_RESET   = 16'h4127;
    localparam logic [15:0] RESULT_RESET  = 16'h0000;
    localparam logic [15:0] SCALING_RESET = 16'h0000;
    localparam logic [7:0]  UNMAPPED_BYTE = 8'h00;

    // Field positions
    localparam int SETUP_SOFT_RESET_BIT = 15;
    localparam int RAIL_CODE_MSB        = 14;

    // Current scaling: divide by 2048 is a shift of 11, truncation adds 2047 when negative
    localparam int           CUR_DIV_SHIFT = 11;
    localparam logic [32:0]  CUR_TRUNC_ADJ = 33'h0000007ff;

    // Power divisor and its quotient weight (25 current steps per power step)
    localparam logic [15:0]  POWER_DIVISOR   = 16'h4e20;
    localparam int           POWER_LSB_RATIO = 25;
    localparam int           DIV_STEPS       = 32;
    localparam logic [5:0]   DIV_LAST_STEP   = 6'h1f;

    // Byte order of a 16-bit register on the two-wire bus
    localparam logic BYTE_HIGH = 1'b0;
    localparam logic BYTE_LOW  = 1'b1;

    // One conversion result from the measurement front end
    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } cpe_conv_t;

    // Power divider states
    typedef enum logic [0:0] {
        DIV_IDLE = 1'b0,
        DIV_RUN  = 1'b1
    } cpe_div_state_t;

endpackage : cpe_pkg

// >>> verilog/cpe_divider.sv
// Sequential restoring divider by the fixed power divisor
`timescale 1ns/1ns
`default_nettype none
module cpe_divider (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    output logic             busy,
    output logic             done,
    output logic [15:0]      quotient
);
    cpe_pkg::cpe_div_state_t state_reg, state_next;
    logic [31:0] shift_reg, shift_next;
    logic [16:0] rem_reg,   rem_next;
    logic [5:0]  step_reg,  step_next;
    logic        done_reg,  done_next;
    logic [15:0] quot_reg,  quot_next;
    logic [16:0] trial;

    // Next state of the divider, one quotient bit per cycle
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        rem_next   = rem_reg;
        step_next  = step_reg;
        done_next  = 1'b0;
        quot_next  = quot_reg;
        trial      = {rem_reg[15:0], shift_reg[31]};
        unique case (state_reg)
            cpe_pkg::DIV_IDLE: begin
                if (start) begin
                    shift_next = dividend;
                    rem_next   = '0;
                    step_next  = '0;
                    state_next = cpe_pkg::DIV_RUN;
                end
            end
            cpe_pkg::DIV_RUN: begin
                // RULE13: quotient truncated, remainder dropped
                if (trial >= {1'b0, cpe_pkg::POWER_DIVISOR}) begin
                    rem_next   = trial - {1'b0, cpe_pkg::POWER_DIVISOR};
                    shift_next = {shift_reg[30:0], 1'b1};
                end else begin
                    rem_next   = trial;
                    shift_next = {shift_reg[30:0], 1'b0};
                end
                step_next = step_reg + 6'h01;
                if (step_reg == cpe_pkg::DIV_LAST_STEP) begin
                    quot_next  = shift_next[15:0];
                    done_next  = 1'b1;
                    state_next = cpe_pkg::DIV_IDLE;
                end
            end
        endcase
    end

    // Divider registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= cpe_pkg::DIV_IDLE;
            shift_reg <= '0;
            rem_reg   <= '0;
            step_reg  <= '0;
            done_reg  <= 1'b0;
            quot_reg  <= '0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            rem_reg   <= rem_next;
            step_reg  <= step_next;
            done_reg  <= done_next;
            quot_reg  <= quot_next;
        end
    end

    assign busy     = (state_reg == cpe_pkg::DIV_RUN);
    assign done     = done_reg;
    assign quotient = quot_reg;
endmodule : cpe_divider
`default_nettype wire

// >>> verilog/cpe_engine.sv
// Current and power calculation engine with its result registers
//
// Function
// RULE1: Current equals shunt code times scaling word over 2048, after each shunt conversion.
// RULE2: Power equals current times rail voltage code over 20000.
// RULE3: Power step is fixed at 25 current steps by that divisor.
// RULE4: With scaling word zero, current and power results stay zero.
// RULE5: Once scaling is set, each new conversion refreshes current and power.
// RULE6: Rail voltage result is unsigned code, step 1.25 mV.
// RULE7: Top bit of rail voltage result always reads zero.
// RULE8: Current at index 04h, power at 03h, rail voltage at 02h.
// RULE9: Host computes scaling word as 0.00512 over current step times resistance.
// RULE10: Host picks current step at least maximum current over 2 to 15.
// RULE11: Host may trim scaling word by measured over reported current ratio.
// RULE12: Every 16-bit register moves as two bytes, high byte first.
// RULE13: Current and power quotients are truncated into 16-bit values.
`timescale 1ns/1ns
`default_nettype none
module cpe_engine (
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    input  wire cpe_pkg::cpe_conv_t shunt_conv,
    input  wire cpe_pkg::cpe_conv_t rail_conv,
    input  wire logic               ptr_wr,
    input  wire logic [7:0]         ptr_val,
    input  wire logic               byte_wr,
    input  wire logic [7:0]         byte_wdata,
    input  wire logic               byte_rd,
    output logic [7:0]              byte_rdata,
    output logic [15:0]             setup_word,
    output logic                    power_busy
);
    logic [15:0] setup_reg,   setup_next;
    logic [15:0] shunt_reg,   shunt_next;
    logic [15:0] rail_reg,    rail_next;
    logic [15:0] power_reg,   power_next;
    logic [15:0] current_reg, current_next;
    logic [15:0] scale_reg,   scale_next;
    logic [7:0]  ptr_reg,     ptr_next;
    logic        phase_reg,   phase_next;
    logic [7:0]  hi_reg,      hi_next;
    logic [7:0]  lo_hold_reg, lo_hold_next;
    logic [7:0]  rdata_reg,   rdata_next;
    logic        pend_reg,    pend_next;

    logic signed [32:0] cur_prod;
    logic signed [32:0] cur_adj;
    logic signed [32:0] cur_quot;
    logic [15:0]        cur_fresh;
    logic [15:0]        cur_use;
    logic [15:0]        cur_mag;
    logic [31:0]        pwr_dividend;
    logic               div_start;
    logic               div_busy;
    logic               div_done;
    logic [15:0]        div_quot;
    logic [15:0]        wr_word;
    logic               soft_rst;

    // Register read decode, used only for the read snapshot on the high byte
    function automatic logic [15:0] read_word(input logic [7:0] idx,
                                              input logic [15:0] s0, input logic [15:0] s1,
                                              input logic [15:0] s2, input logic [15:0] s3,
                                              input logic [15:0] s4, input logic [15:0] s5);
        logic [15:0] w;
        w = cpe_pkg::RESULT_RESET;
        case (idx)
            cpe_pkg::IDX_OPERATING_SETUP: w = s0;
            cpe_pkg::IDX_SHUNT_DROP:      w = s1;
            // RULE8: rail, power and current index map
            cpe_pkg::IDX_RAIL_VOLTAGE:    w = s2;
            cpe_pkg::IDX_POWER:           w = s3;
            cpe_pkg::IDX_CURRENT:         w = s4;
            cpe_pkg::IDX_SCALING_WORD:    w = s5;
            default:                      w = cpe_pkg::RESULT_RESET;
        endcase
        return w;
    endfunction : read_word

    // Current from the incoming shunt code, truncated toward zero
    always_comb begin
        // RULE1: signed shunt times scaling word over 2048
        cur_prod  = $signed({{17{shunt_conv.value[15]}}, shunt_conv.value})
                  * $signed({17'h00000, scale_reg});
        // RULE13: truncation toward zero before the shift
        cur_adj   = cur_prod[32] ? (cur_prod + $signed(cpe_pkg::CUR_TRUNC_ADJ)) : cur_prod;
        cur_quot  = cur_adj >>> cpe_pkg::CUR_DIV_SHIFT;
        cur_fresh = cur_quot[15:0];
        cur_use   = current_next;
        cur_mag   = cur_use[15] ? (16'h0000 - cur_use) : cur_use;
        // RULE2: product of current magnitude and rail code feeds the divider
        pwr_dividend = cur_mag * rail_next;
    end

    // Byte assembly for writes
    assign wr_word  = {hi_reg, byte_wdata};
    assign soft_rst = byte_wr && (phase_reg == cpe_pkg::BYTE_LOW)
                    && (ptr_reg == cpe_pkg::IDX_OPERATING_SETUP)
                    && wr_word[cpe_pkg::SETUP_SOFT_RESET_BIT];

    // Next values of registers, byte port and power request
    always_comb begin
        setup_next   = setup_reg;
        shunt_next   = shunt_reg;
        rail_next    = rail_reg;
        power_next   = power_reg;
        current_next = current_reg;
        scale_next   = scale_reg;
        ptr_next     = ptr_reg;
        phase_next   = phase_reg;
        hi_next      = hi_reg;
        lo_hold_next = lo_hold_reg;
        rdata_next   = rdata_reg;
        pend_next    = pend_reg;
        div_start    = 1'b0;

        // Conversion results
        if (shunt_conv.valid) begin
            shunt_next = shunt_conv.value;
            // RULE5: refresh current on each shunt conversion
            current_next = cur_fresh;
        end
        if (rail_conv.valid) begin
            // RULE6: unsigned code, top bit cleared below
            // RULE7: top bit forced to zero
            rail_next = {1'b0, rail_conv.value[cpe_pkg::RAIL_CODE_MSB:0]};
            pend_next = 1'b1;
        end
        if (pend_reg && !div_busy) begin
            div_start = 1'b1;
            pend_next = rail_conv.valid;
        end
        // RULE5: power refreshed when the division ends
        if (div_done) begin
            power_next = div_quot;
        end

        // RULE12: pointer then bytes, high byte first
        if (ptr_wr) begin
            ptr_next   = ptr_val;
            phase_next = cpe_pkg::BYTE_HIGH;
        end else if (byte_wr) begin
            if (phase_reg == cpe_pkg::BYTE_HIGH) begin
                hi_next    = byte_wdata;
                phase_next = cpe_pkg::BYTE_LOW;
            end else begin
                phase_next = cpe_pkg::BYTE_HIGH;
                if (ptr_reg == cpe_pkg::IDX_OPERATING_SETUP) begin
                    setup_next = wr_word;
                end else if (ptr_reg == cpe_pkg::IDX_SCALING_WORD) begin
                    scale_next = wr_word;
                end
            end
        end else if (byte_rd) begin
            // RULE12: snapshot the word on the high byte
            if (phase_reg == cpe_pkg::BYTE_HIGH) begin
                {rdata_next, lo_hold_next} = read_word(ptr_reg, setup_reg, shunt_reg, rail_reg,
                                                       power_reg, current_reg, scale_reg);
                phase_next = cpe_pkg::BYTE_LOW;
            end else begin
                rdata_next = lo_hold_reg;
                phase_next = cpe_pkg::BYTE_HIGH;
            end
        end

        // RULE4: no scaling word, no current or power
        if (scale_next == cpe_pkg::SCALING_RESET) begin
            current_next = cpe_pkg::RESULT_RESET;
            power_next   = cpe_pkg::RESULT_RESET;
        end

        // Soft reset returns registers 00h to 05h to their defaults; the byte port keeps its state; the bit self-clears
        if (soft_rst) begin
            setup_next   = cpe_pkg::SETUP_RESET;
            shunt_next   = cpe_pkg::RESULT_RESET;
            rail_next    = cpe_pkg::RESULT_RESET;
            power_next   = cpe_pkg::RESULT_RESET;
            current_next = cpe_pkg::RESULT_RESET;
            scale_next   = cpe_pkg::SCALING_RESET;
            pend_next    = 1'b0;
        end
    end

    // Register storage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            setup_reg   <= cpe_pkg::SETUP_RESET;
            shunt_reg   <= cpe_pkg::RESULT_RESET;
            rail_reg    <= cpe_pkg::RESULT_RESET;
            power_reg   <= cpe_pkg::RESULT_RESET;
            current_reg <= cpe_pkg::RESULT_RESET;
            scale_reg   <= cpe_pkg::SCALING_RESET;
            ptr_reg     <= cpe_pkg::IDX_OPERATING_SETUP;
            phase_reg   <= cpe_pkg::BYTE_HIGH;
            hi_reg      <= cpe_pkg::UNMAPPED_BYTE;
            lo_hold_reg <= cpe_pkg::UNMAPPED_BYTE;
            rdata_reg   <= cpe_pkg::UNMAPPED_BYTE;
            pend_reg    <= 1'b0;
        end else begin
            setup_reg   <= setup_next;
            shunt_reg   <= shunt_next;
            rail_reg    <= rail_next;
            power_reg   <= power_next;
            current_reg <= current_next;
            scale_reg   <= scale_next;
            ptr_reg     <= ptr_next;
            phase_reg   <= phase_next;
            hi_reg      <= hi_next;
            lo_hold_reg <= lo_hold_next;
            rdata_reg   <= rdata_next;
            pend_reg    <= pend_next;
        end
    end

    // RULE3: fixed divisor sets power step at 25 current steps
    cpe_divider u_power_div (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst || soft_rst),
        .start    (div_start),
        .dividend (pwr_dividend),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_quot)
    );

    // Outputs; busy also spans the cycle in which the new power result lands
    assign byte_rdata = rdata_reg;
    assign setup_word = setup_reg;
    assign power_busy = div_busy || pend_reg || div_done;
endmodule : cpe_engine
`default_nettype wire

// >>> testbench/cpe_engine_chk.sv
// Port-level assertions for the current and power calculation engine
`timescale 1ns/1ns
`default_nettype none
module cpe_engine_chk (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire cpe_pkg::cpe_conv_t shunt_conv,
    input wire cpe_pkg::cpe_conv_t rail_conv,
    input wire logic               ptr_wr,
    input wire logic [7:0]         ptr_val,
    input wire logic               byte_wr,
    input wire logic [7:0]         byte_wdata,
    input wire logic               byte_rd,
    input wire logic [7:0]         byte_rdata,
    input wire logic [15:0]        setup_word,
    input wire logic               power_busy
);
    localparam int BUSY_MAX = 80;
    logic [7:0] busy_cnt_reg;
    logic [7:0] busy_cnt_next;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // Length of the current busy window
    always_comb begin
        busy_cnt_next = power_busy ? busy_cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk_sys) begin
        busy_cnt_reg <= sys_rst ? 8'h00 : busy_cnt_next;
    end
    // Pointer load followed at once by a read, or by two byte writes
    sequence s_rail_read;
        ptr_wr && ptr_val == cpe_pkg::IDX_RAIL_VOLTAGE ##1 byte_rd;
    endsequence
    sequence s_gap_read;
        ptr_wr && ptr_val > cpe_pkg::IDX_SCALING_WORD ##1 byte_rd;
    endsequence
    sequence s_soft_rst;
        ptr_wr && ptr_val == cpe_pkg::IDX_OPERATING_SETUP ##1 byte_wr && byte_wdata[7] ##1 byte_wr;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !power_busy && byte_rdata == 8'h00)
        else $error("reset state wrong");
    a_rail_msb_zero: assert property (s_rail_read |=> !byte_rdata[7])
        else $error("rail top bit set");
    a_gap_reads_zero: assert property (s_gap_read |=> byte_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!byte_rd && !byte_wr && !$past(byte_wr) && !$past(byte_wr, 2) |=> $stable(byte_rdata))
        else $error("read data moved");
    a_setup_holds: assert property (!byte_wr && !$past(byte_wr) && !$past(byte_wr, 2) |=> $stable(setup_word))
        else $error("setup word moved");
    a_soft_reset: assert property (s_soft_rst |-> ##[1:4] setup_word == cpe_pkg::SETUP_RESET)
        else $error("soft reset missing");
    // busy only from a rail result
    a_busy_cause: assert property ($rose(power_busy) |-> $past(rail_conv.valid))
        else $error("busy without rail result");
    a_busy_bound: assert property (busy_cnt_reg < BUSY_MAX)
        else $error("power busy too long");
endmodule : cpe_engine_chk
bind cpe_engine cpe_engine_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .shunt_conv(shunt_conv),
    .rail_conv(rail_conv), .ptr_wr(ptr_wr), .ptr_val(ptr_val), .byte_wr(byte_wr), .byte_wdata(byte_wdata),
    .byte_rd(byte_rd), .byte_rdata(byte_rdata), .setup_word(setup_word), .power_busy(power_busy));
`default_nettype wire

// >>> testbench/cpe_host_model.sv
// Host controller model on the byte-level register port
`timescale 1ns/1ns
`default_nettype none
module cpe_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] byte_rdata,
    output logic            ptr_wr,
    output logic [7:0]      ptr_val,
    output logic            byte_wr,
    output logic [7:0]      byte_wdata,
    output logic            byte_rd
);
    // Idle port at time zero
    initial begin
        ptr_wr = 1'b0;
        ptr_val = 8'h00;
        byte_wr = 1'b0;
        byte_wdata = 8'h00;
        byte_rd = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] idx, input logic [15:0] val);
        @(posedge clk_sys);
        ptr_wr <= 1'b1;
        ptr_val <= idx;
        @(posedge clk_sys);
        ptr_wr <= 1'b0;
        byte_wr <= 1'b1;
        byte_wdata <= val[15:8];
        @(posedge clk_sys);
        byte_wdata <= val[7:0];
        @(posedge clk_sys);
        byte_wr <= 1'b0;
        byte_wdata <= ~val[7:0]; // Released data looks stale
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] idx, output logic [15:0] val);
        @(posedge clk_sys);
        ptr_wr <= 1'b1;
        ptr_val <= idx;
        @(posedge clk_sys);
        ptr_wr <= 1'b0;
        byte_rd <= 1'b1;
        @(posedge clk_sys);
        #1 val[15:8] = byte_rdata;
        @(posedge clk_sys);
        byte_rd <= 1'b0;
        #1 val[7:0] = byte_rdata;
    endtask : rd_reg
    // scaling word from step and resistance
    function automatic logic [15:0] scale_from(input real step, input real res);
        return 16'($rtoi(0.00512 / (step * res) + 0.5));
    endfunction : scale_from
    function automatic logic [15:0] scale_trim(input int cal, input int meas, input int rep);
        return 16'(cal * meas / rep);
    endfunction : scale_trim
endmodule : cpe_host_model
`default_nettype wire

// >>> testbench/cpe_engine_bench.sv
// Self-checking bench for the current and power calculation engine
`timescale 1ns/1ns
`default_nettype none
module cpe_engine_bench;
    logic               clk_sys;
    logic               sys_rst;
    cpe_pkg::cpe_conv_t shunt_conv;
    cpe_pkg::cpe_conv_t rail_conv;
    logic               ptr_wr;
    logic               byte_wr;
    logic               byte_rd;
    logic               power_busy;
    logic [7:0]         ptr_val;
    logic [7:0]         byte_wdata;
    logic [7:0]         byte_rdata;
    logic [15:0]        setup_word;
    logic [15:0]        rd;
    logic [15:0]        cal;
    int                 n_errors;
    int                 checked;
    int                 mdl [6];
    cpe_engine DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .shunt_conv(shunt_conv), .rail_conv(rail_conv),
        .ptr_wr(ptr_wr), .ptr_val(ptr_val), .byte_wr(byte_wr), .byte_wdata(byte_wdata), .byte_rd(byte_rd),
        .byte_rdata(byte_rdata), .setup_word(setup_word), .power_busy(power_busy));
    cpe_host_model host (.clk_sys(clk_sys), .byte_rdata(byte_rdata), .ptr_wr(ptr_wr), .ptr_val(ptr_val),
        .byte_wr(byte_wr), .byte_wdata(byte_wdata), .byte_rd(byte_rd));
    // 50 MHz clock
    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_cal(input logic [15:0] v);
        host.wr_reg(cpe_pkg::IDX_SCALING_WORD, v);
        mdl[5] = v;
        if (v == 16'h0000) begin
            mdl[3] = 0;
            mdl[4] = 0;
        end
    endtask : wr_cal
    // Shunt then rail result, wait for power, update model
    // Overlap sends a rail result with the shunt one, then the final rail during the pending request
    task automatic measure(input logic [15:0] sh, input logic [15:0] rv, input bit overlap = 1'b0);
        int     i;
        int     mag;
        longint cur;
        @(posedge clk_sys);
        shunt_conv <= '{valid: 1'b1, value: sh};
        rail_conv <= '{valid: overlap, value: rv ^ 16'h0100};
        @(posedge clk_sys);
        shunt_conv <= '{valid: 1'b0, value: ~sh};
        rail_conv <= '{valid: 1'b1, value: rv};
        @(posedge clk_sys);
        rail_conv <= '{valid: 1'b0, value: ~rv};
        #1;
        for (i = 0; i < 100 && power_busy !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check("power busy", {15'h0000, power_busy}, 16'h0000);
        mdl[1] = sh;
        mdl[2] = rv & 16'h7fff;
        cur = longint'(mdl[1] >= 32768 ? mdl[1] - 65536 : mdl[1]) * mdl[5] / 2048;
        mdl[4] = mdl[5] == 0 ? 0 : int'(cur & 65535);
        mag = mdl[4] >= 32768 ? 65536 - mdl[4] : mdl[4];
        mdl[3] = mdl[5] == 0 ? 0 : int'((longint'(mag) * mdl[2] / 20000) & 65535);
    endtask : measure
    task automatic check_all();
        for (int k = 1; k < 6; k++) begin
            host.rd_reg(8'(k), rd);
            check($sformatf("register %0d", k), rd, 16'(mdl[k]));
        end
    endtask : check_all
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        shunt_conv = '0;
        rail_conv = '0;
        sys_rst = 1'b1;
        n_errors = 0;
        checked = 0;
        mdl = '{16'h4127, 0, 0, 0, 0, 0};
        void'($urandom(32'h4bf9));
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        host.rd_reg(cpe_pkg::IDX_OPERATING_SETUP, rd);
        check("setup reset", rd, cpe_pkg::SETUP_RESET);
        check_all();
        $display("test reset done");
        // 15 A over 2 to 15 rounds up to 1 mA
        wr_cal(host.scale_from(0.001, 0.002));
        measure(16'h1f40, 16'h2570);
        host.rd_reg(cpe_pkg::IDX_CURRENT, rd);
        check("example current", rd, 16'h2710);
        host.rd_reg(cpe_pkg::IDX_POWER, rd);
        check("example power", rd, 16'h12b8);
        wr_cal(host.scale_trim(mdl[5], 10200, 10000));
        measure(16'h1f40, 16'h2570);
        host.wr_reg(cpe_pkg::IDX_POWER, 16'h5a5a);
        check_all();
        host.rd_reg(8'h09, rd);
        check("unmapped", rd, 16'h0000);
        host.wr_reg(cpe_pkg::IDX_OPERATING_SETUP, 16'h4527);
        host.rd_reg(cpe_pkg::IDX_OPERATING_SETUP, rd);
        check("setup written", rd, 16'h4527);
        check("setup port", setup_word, 16'h4527);
        $display("test example done");
        for (int t = 0; t < 30; t++) begin
            cal = (t % 4 == 0) ? 16'h0000 : 16'($urandom);
            wr_cal(cal);
            check_all();
            measure(16'($urandom), 16'($urandom), t % 2 == 1);
            check_all();
        end
        $display("test random done");
        host.wr_reg(cpe_pkg::IDX_OPERATING_SETUP, 16'h8000);
        mdl = '{16'h4127, 0, 0, 0, 0, 0};
        host.rd_reg(cpe_pkg::IDX_OPERATING_SETUP, rd);
        check("setup after soft reset", rd, cpe_pkg::SETUP_RESET);
        check("setup port after soft reset", setup_word, cpe_pkg::SETUP_RESET);
        check_all();
        $display("test soft reset done");
        final_report();
    end
    // Watchdog
    initial begin
        #400000;
        n_errors++;
        final_report();
    end
endmodule : cpe_engine_bench
`default_nettype wire
